// file: hdl/ddff_pkg.sv
// Package for the dual storage element block: constants and carrier types.
// Assumes a single 20 MHz system clock and a synchronous active-low reset.
//
// Summary of operation
// - Two identical elements, fully independent of each other.
// - Set low, clear high: true high, complement low.
// - Clear low, set high: true low, complement high.
// - Both low: both outputs high, not retained.
// - Any low control overrides clocked capture.
// - Rising edge, controls high: load data, complement inverse.
// - Data changes after capture leave outputs alone.
package ddff_pkg;

    // ****************************************************************
    // Constants
    // ****************************************************************

    // Number of storage elements in the block.
    localparam int unsigned DDFF_NUM_ELEM = 2;

    // Depth of the pin input synchroniser.
    localparam int unsigned DDFF_SYNC_LEN = 3;

    // Reset value of the stored true output.
    localparam logic DDFF_RST_TRUE = 1'h0;

    // Reset value of the pin synchroniser stages (controls idle high).
    localparam logic [2:0] DDFF_RST_SYNC_HI = 3'h7;
    localparam logic [2:0] DDFF_RST_SYNC_LO = 3'h0;

    // Clock period in nanoseconds.
    localparam int unsigned DDFF_CLK_NS = 50;

    // ****************************************************************
    // Carrier types
    // ****************************************************************

    // Pin inputs of one element.
    typedef struct packed {
        logic data;          // Data input.
        logic edge_clk;      // Element clock pin, sampled.
        logic async_set_n;   // Active-low set.
        logic async_clear_n; // Active-low clear.
    } ddff_in_t;

    // Outputs of one element.
    typedef struct packed {
        logic q_true;        // True output.
        logic q_comp;        // Complement output.
    } ddff_out_t;

endpackage

// file: hdl/ddff_elem.sv
// One storage element: synchronises its pins and produces both outputs.
// Assumes its pins are asynchronous to clk and held for several clock periods.
`timescale 1ns/10ps
module ddff_elem
    import ddff_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  wire logic      ce,
    input  wire ddff_in_t  pins,
    output ddff_out_t      outs
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************

    // Three stages per pin; stage 0 is read only by stage 1.
    logic [2:0] data_ff;
    logic [2:0] clk_ff;
    logic [2:0] set_ff;
    logic [2:0] clear_ff;

    // Shift every pin through its chain while enabled.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_ff <= DDFF_RST_SYNC_LO;
            clk_ff  <= DDFF_RST_SYNC_LO;
            set_ff  <= DDFF_RST_SYNC_HI;
            clear_ff <= DDFF_RST_SYNC_HI;
        end else if (ce) begin
            data_ff <= {data_ff[1:0], pins.data};
            clk_ff  <= {clk_ff[1:0], pins.edge_clk};
            set_ff  <= {set_ff[1:0], pins.async_set_n};
            clear_ff <= {clear_ff[1:0], pins.async_clear_n};
        end
    end

    // ****************************************************************
    // Filtered levels
    // ****************************************************************

    // A level changes only when stages 1 and 2 agree.
    logic data_lvl_ff;
    logic clk_lvl_ff;
    logic set_lvl_ff;
    logic clear_lvl_ff;
    logic clk_prev_ff;

    // Accept agreed levels; remember the previous clock level.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_lvl_ff <= 1'h0;
            clk_lvl_ff  <= 1'h0;
            set_lvl_ff  <= 1'h1;
            clear_lvl_ff <= 1'h1;
            clk_prev_ff <= 1'h0;
        end else if (ce) begin
            if (data_ff[1] == data_ff[2]) data_lvl_ff <= data_ff[2];
            if (clk_ff[1] == clk_ff[2]) clk_lvl_ff <= clk_ff[2];
            if (set_ff[1] == set_ff[2]) set_lvl_ff <= set_ff[2];
            if (clear_ff[1] == clear_ff[2]) clear_lvl_ff <= clear_ff[2];
            clk_prev_ff <= clk_lvl_ff;
        end
    end

    // ****************************************************************
    // Storage and outputs
    // ****************************************************************

    // Rising edge of the filtered element clock.
    logic rise;
    assign rise = clk_lvl_ff & ~clk_prev_ff;

    // Stored value; updated by capture or by a single active control.
    logic stored_ff;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stored_ff <= DDFF_RST_TRUE;
        end else if (ce) begin
            if (!set_lvl_ff && clear_lvl_ff) begin
                stored_ff <= 1'h1;
            end else if (set_lvl_ff && !clear_lvl_ff) begin
                stored_ff <= 1'h0;
            end else if (set_lvl_ff && clear_lvl_ff && rise) begin
                stored_ff <= data_lvl_ff;
            end
            // Otherwise hold; data changes alone do nothing.
        end
    end

    // Outputs from flip-flops, computed from the next state.
    logic nxt_true;
    logic nxt_comp;
    always_comb begin
        nxt_true = outs.q_true;
        nxt_comp = outs.q_comp;
        if (!set_lvl_ff && !clear_lvl_ff) begin
            nxt_true = 1'h1;
            nxt_comp = 1'h1;
        end else if (!set_lvl_ff) begin
            nxt_true = 1'h1;
            nxt_comp = 1'h0;
        end else if (!clear_lvl_ff) begin
            nxt_true = 1'h0;
            nxt_comp = 1'h1;
        end else if (rise) begin
            nxt_true = data_lvl_ff;
            nxt_comp = ~data_lvl_ff;
        end else begin
            nxt_true = stored_ff;
            nxt_comp = ~stored_ff;
        end
    end

    // Register the outputs.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            outs.q_true <= DDFF_RST_TRUE;
            outs.q_comp <= ~DDFF_RST_TRUE;
        end else if (ce) begin
            outs.q_true <= nxt_true;
            outs.q_comp <= nxt_comp;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    set_forces_high_a: assert property (ce && !set_lvl_ff && clear_lvl_ff |=>
        outs.q_true && !outs.q_comp) else $error("set did not force high");
    clear_forces_low_a: assert property (ce && set_lvl_ff && !clear_lvl_ff |=>
        !outs.q_true && outs.q_comp) else $error("clear did not force low");
    both_low_high_a: assert property (ce && !set_lvl_ff && !clear_lvl_ff |=>
        outs.q_true && outs.q_comp) else $error("both low not both high");
    capture_loads_a: assert property (ce && set_lvl_ff && clear_lvl_ff && rise |=>
        outs.q_true == $past(data_lvl_ff) && outs.q_comp != outs.q_true)
        else $error("edge did not capture data");
    hold_no_edge_a: assert property (ce && set_lvl_ff && clear_lvl_ff && !rise
        && $past(set_lvl_ff && clear_lvl_ff) |=> $stable(outs.q_true))
        else $error("output changed without edge");
    data_ignored_a: assert property (ce && set_lvl_ff && clear_lvl_ff && !rise
        && $past(set_lvl_ff && clear_lvl_ff) && $changed(data_lvl_ff)
        |=> outs.q_true == $past(outs.q_true)) else $error("data leaked");

    cover_capture_c: cover property (ce && set_lvl_ff && clear_lvl_ff && rise);
    cover_both_low_c: cover property (ce && !set_lvl_ff && !clear_lvl_ff);
    cover_release_c: cover property (ce && !set_lvl_ff && !clear_lvl_ff ##1
        set_lvl_ff && clear_lvl_ff);

endmodule

// file: hdl/ddff_top.sv
// Top of the dual storage element block: two independent elements.
// Assumes every pin is asynchronous to clk and lasts over three clock periods.
`timescale 1ns/10ps
module ddff_top
    import ddff_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    ce,
    input  wire ddff_in_t  [1:0]         pins,
    output wire ddff_out_t [1:0]         outs
);

    // ****************************************************************
    // Element instances
    // ****************************************************************

    // Each element sees only its own pins and drives only its own outputs.
    for (genvar i = 0; i < DDFF_NUM_ELEM; i++) begin : g_elem
        ddff_elem u_elem (
            .clk   (clk),
            .rst_n (rst_n),
            .ce    (ce),
            .pins  (pins[i]),
            .outs  (outs[i])
        );
    end

    // Helper for the isolation check: edges run since reset or a frozen cycle.
    // A frozen pipeline may still carry an old pin change, so the check waits
    // until every stage has been clocked through since the last freeze.
    logic [3:0] run_ff;
    always_ff @(posedge clk) begin
        if (!rst_n || !ce) begin
            run_ff <= 4'h0;
        end else if (run_ff != 4'hf) begin
            run_ff <= run_ff + 4'h1;
        end
    end

    // Activity on element zero leaves element one's outputs alone.
    // A pin change reaches the outputs four edges after it is sampled.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    elem_isolated_a: assert property (ce && run_ff >= 4'ha && $stable(pins[1])
        && $stable($past(pins[1])) && $stable($past(pins[1], 2))
        && $stable($past(pins[1], 3)) && $stable($past(pins[1], 4))
        && $stable($past(pins[1], 5))
        |-> $stable(outs[1])) else $error("element one disturbed");
    cover_both_c: cover property (ce && $changed(outs[0]) && $changed(outs[1]));

endmodule

// file: verif/ddff_pin_drv.sv
// Partner model: the logic that drives the pins of one element.
// Assumes the bench asks for new levels no faster than every eight clocks.
`timescale 1ns/10ps
module ddff_pin_drv
    import ddff_pkg::*;
(
    input  wire logic     clk,
    input  wire ddff_in_t want,
    output ddff_in_t      pins
);
    // Pins move just after an edge, then stand still as plain levels.
    always @(posedge clk) begin
        pins <= want;
    end
endmodule

// file: verif/ddff_top_tb.sv
// Self-checking bench for the dual storage element block.
// Assumes outputs settle within seven clocks of a pin change.
`timescale 1ns/10ps
module ddff_top_tb
    import ddff_pkg::*;
;
    // ****
    // Signals
    // ****
    logic            clk = 1'b0;       // System clock.
    logic            rst_n = 1'b0;     // Synchronous reset.
    logic            ce = 1'b1;        // Clock enable, dropped during frozen steps.
    ddff_in_t  [1:0] want;             // Levels asked of the partner.
    wire ddff_in_t [1:0] pins;         // Pins seen by the block, one driver per element.
    ddff_out_t [1:0] outs;             // Block outputs.
    logic      [1:0] stored;           // Expected stored bits.
    logic      [3:0] tbl [20];         // Corner steps: elem, field, value.
    logic     [31:0] rnd = 32'h34;     // Random state, seeded.
    int              err_count = 0;    // Mismatches.
    int              comparisons = 0;  // Checks made.
    int              cycles = 0;       // Timeout counter.

    always #25 clk = ~clk;

    // Partner models, one per element, and the block itself.
    for (genvar g = 0; g < 2; g++) begin : g_drv
        ddff_pin_drv u_drv (.clk(clk), .want(want[g]), .pins(pins[g]));
    end
    ddff_top dut (.clk(clk), .rst_n(rst_n), .ce(ce), .pins(pins), .outs(outs));

    // Cut a hang short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            err_count++;
            report_and_stop();
        end
    end

    // ****
    // Expectation functions
    // ****
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    // Output levels from the stored bit and the control levels.
    function automatic ddff_out_t exp_out(input logic st, input ddff_in_t p);
        if (!p.async_set_n && !p.async_clear_n) return 2'h3;
        if (!p.async_set_n) return 2'h2;
        if (!p.async_clear_n) return 2'h1;
        return {st, ~st};
    endfunction

    // New stored bit; only one field changes per step.
    function automatic logic nxt_st(input logic st, input ddff_in_t o, input ddff_in_t p);
        if (!p.async_set_n && p.async_clear_n) return 1'h1;
        if (p.async_set_n && !p.async_clear_n) return 1'h0;
        if (p.async_set_n && p.async_clear_n && !o.edge_clk && p.edge_clk) return p.data;
        return st;
    endfunction

    // ****
    // Tasks
    // ****
    task automatic check(input int k);
        ddff_out_t e;
        e = exp_out(stored[k], want[k]);
        comparisons++;
        if (outs[k] !== e) begin
            err_count++;
            $display("[FAIL] t=%0t elem %0d got %h exp %h", $time, k, outs[k], e);
        end
    endtask

    // Change one pin field of one element, wait, then check both.
    task automatic step(input logic [3:0] c);
        ddff_in_t p;
        p = want[c[3]];
        p[c[2:1]] = c[0];
        @(posedge clk);
        stored[c[3]] = nxt_st(stored[c[3]], want[c[3]], p);
        want[c[3]] <= p;
        repeat (8) @(posedge clk);
        check(0);
        check(1);
    endtask

    // Freeze the block, change one pin field, expect the old outputs to stand,
    // then release the enable and expect the change to arrive.
    task automatic frozen_step(input logic [3:0] c);
        ddff_in_t  p;
        ddff_out_t e;
        p = want[c[3]];
        p[c[2:1]] = c[0];
        e = exp_out(stored[c[3]], want[c[3]]);
        @(posedge clk);
        ce <= 1'b0;
        stored[c[3]] = nxt_st(stored[c[3]], want[c[3]], p);
        want[c[3]] <= p;
        repeat (8) @(posedge clk);
        comparisons++;
        if (outs[c[3]] !== e) begin
            err_count++;
            $display("[FAIL] t=%0t frozen elem %0d got %h exp %h", $time, c[3], outs[c[3]], e);
        end
        ce <= 1'b1;
        repeat (8) @(posedge clk);
        check(0);
        check(1);
    endtask

    task automatic report_and_stop();
        if (err_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ****
    // Main sequence
    // ****
    initial begin
        want = {4'h3, 4'h3};
        stored = 2'h0;
        tbl = '{4'h7, 4'h5, 4'h6, 4'h4, 4'h0, 4'h7, 4'h5, 4'h4, 4'h2, 4'h1,
                4'h0, 4'h3, 4'h1, 4'hf, 4'hd, 4'ha, 4'hb, 4'he, 4'hc, 4'hd};
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        check(0);
        check(1);
        // Hand-picked corners: capture, hold, override, both low, release.
        foreach (tbl[i]) step(tbl[i]);
        // Frozen block: a clear and its release must wait for the enable.
        frozen_step(4'h0);
        frozen_step(4'h1);
        // Random single-field changes on either element.
        repeat (300) begin
            rnd = xs(rnd);
            if (rnd[7:5] == 3'h0) begin
                frozen_step(rnd[3:0]);
            end else begin
                step(rnd[3:0]);
            end
        end
        report_and_stop();
    end
endmodule
